//--- pkg/erb_pkg.sv
package erb_pkg;
   // storage shape: one array of rows, each row one byte wide
   localparam int TOTAL_BITS = 2048;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int ROWS = 256;
   localparam int ROW_W = 8;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] DEPTH_MAX = 12'h800;

   // shape codes, words by bits
   localparam logic [1:0] SHAPE_256X8 = 2'h0;
   localparam logic [1:0] SHAPE_512X4 = 2'h1;
   localparam logic [1:0] SHAPE_1KX2 = 2'h2;
   localparam logic [1:0] SHAPE_2KX1 = 2'h3;

   // use of the block
   typedef enum logic [1:0] {
      ERB_RAM = 2'h0,
      ERB_ROM = 2'h1,
      ERB_DPRAM = 2'h3,
      ERB_FIFO = 2'h2
   } erb_mode_e;

   // register port
   localparam int BUS_AW = 4;
   localparam int BUS_DW = 32;
   localparam logic [BUS_AW-1:0] REG_CTRL = 4'h0;
   localparam logic [BUS_AW-1:0] REG_STATUS = 4'h4;

   // control fields
   localparam int CTRL_W = 7;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SHAPE_LSB = 2;
   localparam int CTRL_REG_DIN = 4;
   localparam int CTRL_REG_DOUT = 5;
   localparam int CTRL_REG_ADDR = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

   // status fields
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_EMPTY = 12;
   localparam int ST_FULL = 13;

   // data bits in use for a shape
   function automatic logic [ROW_W-1:0] erb_lane_mask(input logic [1:0] s);
      logic [ROW_W-1:0] m;
      m = 8'h01;
      unique case (s)
         SHAPE_256X8: m = 8'hff;
         SHAPE_512X4: m = 8'h0f;
         SHAPE_1KX2: m = 8'h03;
         SHAPE_2KX1: m = 8'h01;
      endcase
      return m;
   endfunction

   // bit offset of a word inside its row
   function automatic logic [2:0] erb_lane_off(input logic [1:0] s,
                                               input logic [ADDR_W-1:0] a);
      logic [2:0] l;
      l = a[2:0] & ~(3'h7 << s);
      return l << (2'h3 - s);
   endfunction

   // row holding a word
   function automatic logic [ROW_W-1:0] erb_row(input logic [1:0] s,
                                                input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] t;
      t = a >> s;
      return t[ROW_W-1:0];
   endfunction
endpackage

//--- rtl/erb_bit_array.sv
`timescale 1ns/1ps
module erb_bit_array #(
   parameter int ROWS = 256,
   parameter int WIDTH = 8,
   parameter logic [ROWS*WIDTH-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [$clog2(ROWS)-1:0] wr_row,
   input wire logic [WIDTH-1:0] wr_mask,
   input wire logic [WIDTH-1:0] wr_bits,
   input wire logic [$clog2(ROWS)-1:0] rd_row,
   output logic [WIDTH-1:0] rd_data
);
   // one column of the preload image; a declaration value, not a
   // second process, so the clocked write stays the only writer
   function automatic logic [ROWS-1:0] col_init(input int g);
      logic [ROWS-1:0] c;
      c = '0;
      for (int r = 0; r < ROWS; r++) begin
         c[r] = INIT[r*WIDTH+g];
      end
      return c;
   endfunction

   // one column of storage per data bit so a narrow word writes alone
   for (genvar g = 0; g < WIDTH; g++) begin : g_col
      // contents preloaded at configuration, kept for read-only use
      logic [ROWS-1:0] col = col_init(g);
      logic q;
      // write and registered read share the one clock edge
      always_ff @(posedge clock) begin
         if (wr_en && wr_mask[g]) begin
            col[wr_row] <= wr_bits[g];
         end
         q <= col[rd_row];
      end
      assign rd_data[g] = q;
   end
endmodule

//--- rtl/erb_embedded_ram_block.sv
`timescale 1ns/1ps
module erb_embedded_ram_block #(
   parameter logic [erb_pkg::TOTAL_BITS-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [erb_pkg::BUS_AW-1:0] bus_addr,
   input wire logic [erb_pkg::BUS_DW-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [erb_pkg::BUS_DW-1:0] bus_rdata,
   input wire logic in_ce,
   input wire logic out_ce,
   input wire logic blk_sel,
   input wire logic [erb_pkg::ADDR_W-1:0] addr,
   input wire logic [erb_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [erb_pkg::DATA_W-1:0] wdata,
   input wire logic we,
   input wire logic fifo_pop,
   output logic [erb_pkg::DATA_W-1:0] rdata,
   output logic fifo_empty,
   output logic fifo_full
);
   import erb_pkg::*;

   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic [BUS_DW-1:0] next_bus_rdata;
   logic [ADDR_W-1:0] addr_q, next_addr_q;
   logic we_q, next_we_q;
   logic [DATA_W-1:0] din_q, next_din_q;
   logic [ADDR_W-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [CNT_W-1:0] count, next_count;
   logic next_empty, next_full;
   logic [2:0] off_q, next_off_q;
   logic sel_q, next_sel_q;
   logic [DATA_W-1:0] next_rdata;
   erb_mode_e mode;
   logic [1:0] shape;
   logic reg_din, reg_dout, reg_addr;
   logic [CNT_W-1:0] depth;
   logic [ADDR_W-1:0] amask, a_s, waddr, raddr;
   logic w_s, push, pop, mem_we;
   logic [DATA_W-1:0] d_s, lmask, row_data, ext;

   // configuration fields
   assign mode = erb_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
   assign shape = ctrl[CTRL_SHAPE_LSB +: 2];
   assign reg_din = ctrl[CTRL_REG_DIN];
   assign reg_dout = ctrl[CTRL_REG_DOUT];
   assign reg_addr = ctrl[CTRL_REG_ADDR];

   // register port: control writable, status read-only, rest reads zero
   always_comb begin
      next_ctrl = ctrl;
      next_bus_rdata = '0;
      if (bus_wr && bus_addr == REG_CTRL) begin
         next_ctrl = bus_wdata[CTRL_W-1:0];
      end
      if (bus_rd) begin
         unique case (bus_addr)
            REG_CTRL: next_bus_rdata[CTRL_W-1:0] = ctrl;
            REG_STATUS: begin
               next_bus_rdata[ST_COUNT_LSB +: CNT_W] = count;
               next_bus_rdata[ST_EMPTY] = fifo_empty;
               next_bus_rdata[ST_FULL] = fifo_full;
            end
            default: next_bus_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= CTRL_RESET;
         bus_rdata <= '0;
      end else begin
         ctrl <= next_ctrl;
         bus_rdata <= next_bus_rdata;
      end
   end

   // shape sets depth, address mask and lane width
   // narrowest shape is the deepest, so shift down from the full depth
   assign depth = DEPTH_MAX >> (2'h3 - shape);
   assign amask = ADDR_W'(depth - 12'h001);
   assign lmask = erb_lane_mask(shape);

   // input registers load on the input-side enable
   always_comb begin
      next_addr_q = addr_q;
      next_we_q = we_q;
      next_din_q = din_q;
      if (in_ce) begin
         next_addr_q = addr;
         next_we_q = we;
         next_din_q = wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addr_q <= '0;
         we_q <= 1'b0;
         din_q <= '0;
      end else begin
         addr_q <= next_addr_q;
         we_q <= next_we_q;
         din_q <= next_din_q;
      end
   end

   // each path chooses its register or the live input
   assign a_s = (reg_addr ? addr_q : addr) & amask;
   assign w_s = reg_addr ? we_q : we;
   assign d_s = (reg_din ? din_q : wdata) & lmask;

   // fifo moves; a full push or empty pop is ignored
   assign push = mode == ERB_FIFO && w_s && in_ce && blk_sel &&
                 count != depth;
   assign pop = mode == ERB_FIFO && fifo_pop && out_ce && blk_sel &&
                count != '0;

   // write strobe made here on the input enable; rom never writes
   assign mem_we = push || (in_ce && w_s && blk_sel &&
                   (mode == ERB_RAM || mode == ERB_DPRAM));

   // address source per use of the block
   always_comb begin
      waddr = a_s;
      raddr = a_s;
      unique case (mode)
         ERB_FIFO: begin
            waddr = wptr;
            raddr = rptr;
         end
         ERB_DPRAM: raddr = rd_addr & amask;
         default: raddr = a_s;
      endcase
   end

   // fifo pointers wrap at the depth of the current shape
   always_comb begin
      next_wptr = wptr;
      next_rptr = rptr;
      next_count = count;
      if (push) begin
         next_wptr = ({1'b0, wptr} + 12'h001 == depth) ? '0 :
                     ADDR_W'({1'b0, wptr} + 12'h001);
      end
      if (pop) begin
         next_rptr = ({1'b0, rptr} + 12'h001 == depth) ? '0 :
                     ADDR_W'({1'b0, rptr} + 12'h001);
      end
      if (push && !pop) begin
         next_count = count + 12'h001;
      end else if (pop && !push) begin
         next_count = count - 12'h001;
      end
      // switching away from fifo use flushes it
      if (mode != ERB_FIFO) begin
         next_wptr = '0;
         next_rptr = '0;
         next_count = '0;
      end
      next_empty = next_count == '0;
      next_full = next_count == depth;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         fifo_empty <= 1'b1;
         fifo_full <= 1'b0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         fifo_empty <= next_empty;
         fifo_full <= next_full;
      end
   end

   // storage with preloaded contents and registered row read
   erb_bit_array #(
      .ROWS(ROWS),
      .WIDTH(ROW_W),
      .INIT(INIT)
   ) u_array (
      .clock(clock),
      .wr_en(mem_we),
      .wr_row(erb_row(shape, waddr)),
      .wr_mask(lmask << erb_lane_off(shape, waddr)),
      .wr_bits(d_s << erb_lane_off(shape, waddr)),
      .rd_row(erb_row(shape, raddr)),
      .rd_data(row_data)
   );

   // lane offset and select travel with the row read
   assign next_off_q = erb_lane_off(shape, raddr);
   assign next_sel_q = blk_sel;
   assign ext = (row_data >> off_q) & lmask;

   // bypassed output tracks every cycle, registered waits out_ce
   // a deselected block drives zero (registered output: on its next out_ce) so cascaded outputs can be or-ed
   always_comb begin
      next_rdata = rdata;
      if (!reg_dout || out_ce) begin
         next_rdata = sel_q ? ext : '0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         off_q <= '0;
         sel_q <= 1'b0;
         rdata <= '0;
      end else begin
         off_q <= next_off_q;
         sel_q <= next_sel_q;
         rdata <= next_rdata;
      end
   end

   rom_no_write_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      mode == ERB_ROM |-> !mem_we)
      else $error("write strobe in read-only use");

   // writes only happen on an input-side enable
   write_on_ce_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      mem_we |-> in_ce)
      else $error("write outside input enable");

   // fill level never passes the shape depth
   fifo_depth_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      count <= depth && !(fifo_full && fifo_empty))
      else $error("fifo level out of range");

   // registered output holds between output enables
   dout_hold_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      reg_dout && !out_ce && $stable(ctrl) |=> $stable(rdata))
      else $error("registered output moved without enable");

   // deselected block with bypassed output outputs zero two cycles later
   desel_zero_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      !blk_sel && !reg_dout ##1 !reg_dout |=> rdata == '0)
      else $error("deselected block drove data");

   // byte-wide shape reads the whole row at once
   full_width_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      shape == SHAPE_256X8 ##1 shape == SHAPE_256X8 |-> ext == row_data)
      else $error("wide shape lost lanes");

   // registered address path uses last captured address
   addr_reg_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      reg_addr && in_ce ##1 reg_addr |-> addr_q == $past(addr))
      else $error("address register missed capture");

   // fifo pop without a push lowers level by exactly one
   fifo_level_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      mode == ERB_FIFO && pop && !push ##1 mode == ERB_FIFO
      |-> count == $past(count) - 12'h001)
      else $error("fifo level not decremented");

   // bypassed output reflects the lane read one cycle before
   dout_bypass_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      !reg_dout && sel_q |=> rdata == $past(ext))
      else $error("bypassed output stale");
endmodule

//--- verif/erb_user_logic.sv
`timescale 1ns/1ps
// fabric user logic driving one memory block
module erb_user_logic (
   input wire logic clock,
   output logic in_ce,
   output logic out_ce,
   output logic blk_sel,
   output logic [erb_pkg::ADDR_W-1:0] addr,
   output logic [erb_pkg::ADDR_W-1:0] rd_addr,
   output logic [erb_pkg::DATA_W-1:0] wdata,
   output logic we,
   output logic fifo_pop,
   output logic mem_chk
);
   import erb_pkg::*;

   initial begin
      in_ce = 1'b1;
      out_ce = 1'b1;
      blk_sel = 1'b1;
      addr = '0;
      rd_addr = '1;
      wdata = '0;
      we = 1'b0;
      fifo_pop = 1'b0;
      mem_chk = 1'b0;
   end

   task automatic write_word(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d, input logic ce);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      in_ce <= ce;
      @(posedge clock);
      we <= 1'b0;
      in_ce <= 1'b1;
      wdata <= ~d; // released line must not keep the old value
   endtask

   // address held long enough for either output latency
   task automatic read_word(input logic [ADDR_W-1:0] a, input logic dual);
      @(posedge clock);
      addr <= dual ? ~a : a;
      rd_addr <= dual ? a : ~a;
      repeat (2) @(posedge clock);
      mem_chk <= 1'b1;
      @(posedge clock);
      mem_chk <= 1'b0;
   endtask

   // one pop request on an out_ce cycle
   task automatic pop_word();
      @(posedge clock);
      fifo_pop <= 1'b1;
      @(posedge clock);
      fifo_pop <= 1'b0;
   endtask

   task automatic set_ctl(input logic oc, input logic bs);
      @(posedge clock);
      out_ce <= oc;
      blk_sel <= bs;
   endtask
endmodule

//--- verif/tb_erb_embedded_ram_block.sv
`timescale 1ns/1ps
module tb_erb_embedded_ram_block;
   import erb_pkg::*;
   logic clock, arst_n, bus_wr, bus_rd;
   logic [BUS_AW-1:0] bus_addr;
   logic [BUS_DW-1:0] bus_wdata, bus_rdata;
   logic in_ce, out_ce, blk_sel, we, fifo_pop, mem_chk, fifo_empty, fifo_full;
   logic [ADDR_W-1:0] addr, rd_addr, a;
   logic [DATA_W-1:0] wdata, rdata, d0, d1;
   logic [BUS_DW-1:0] bq[$];
   logic [DATA_W-1:0] mq[$];
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 72;
   logic bnow, mnow;
   logic mc1 = 1'b0;

   // clock at 40 MHz
   initial clock = 1'b0;
   always #12.5 clock = ~clock;

   erb_embedded_ram_block #(.INIT({256{8'h5a}})) erb_embedded_ram_block_i (
      .clock(clock), .arst_n(arst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .in_ce(in_ce), .out_ce(out_ce),
      .blk_sel(blk_sel), .addr(addr), .rd_addr(rd_addr), .wdata(wdata),
      .we(we), .fifo_pop(fifo_pop), .rdata(rdata),
      .fifo_empty(fifo_empty), .fifo_full(fifo_full));

   erb_user_logic erb_user_logic_i (
      .clock(clock), .in_ce(in_ce), .out_ce(out_ce), .blk_sel(blk_sel),
      .addr(addr), .rd_addr(rd_addr), .wdata(wdata), .we(we),
      .fifo_pop(fifo_pop), .mem_chk(mem_chk));

   function automatic logic [7:0] lane(input int s);
      return 8'hff >> (8 - (8 >> s));
   endfunction

   task automatic check(input logic [BUS_DW-1:0] got,
                        input logic [BUS_DW-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic bwr(input logic [BUS_AW-1:0] ad, input logic [BUS_DW-1:0] d);
      @(posedge clock);
      bus_addr <= ad;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask

   task automatic brd(input logic [BUS_AW-1:0] ad, input logic [BUS_DW-1:0] e);
      bq.push_back(e);
      @(posedge clock);
      bus_addr <= ad;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
   endtask

   task automatic mrd(input logic [ADDR_W-1:0] ad, input logic dual,
                      input logic [DATA_W-1:0] e);
      mq.push_back(e);
      erb_user_logic_i.read_word(ad, dual);
   endtask

   // watcher: bus data one cycle after the strobe, rdata two edges later
   always @(posedge clock) begin
      bnow = bus_rd;
      mnow = mem_chk;
      #1;
      if (bnow && bq.size() > 0)
         check(bus_rdata, bq.pop_front());
      if (mc1 && mq.size() > 0)
         check({24'h0, rdata}, {24'h0, mq.pop_front()});
      mc1 = mnow;
   end

   // hang guard, generous for about 700 cycles of traffic
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   // main sequence
   initial begin
      arst_n = 1'b0;
      bus_addr = '0;
      bus_wdata = '0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      brd(REG_CTRL, 32'h0);
      brd(REG_STATUS, 32'h1000);
      brd(4'h8, 32'h0);
      // top two words of every shape, sharing one row where narrow
      for (int s = 0; s < 4; s++) begin
         bwr(REG_CTRL, 32'(s << CTRL_SHAPE_LSB));
         d0 = 8'($random(seed));
         d1 = 8'($random(seed));
         a = 11'((256 << s) - 2);
         erb_user_logic_i.write_word(a, d0, 1'b1);
         erb_user_logic_i.write_word(a + 11'h1, d1, 1'b1);
         mrd(a, 1'b0, d0 & lane(s));
         mrd(a + 11'h1, 1'b0, d1 & lane(s));
      end
      bwr(REG_CTRL, 32'h0);
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      erb_user_logic_i.write_word(11'd30, 8'h77, 1'b0);
      mrd(11'd30, 1'b0, 8'h5a);
      erb_user_logic_i.write_word(11'd30, d0, 1'b1);
      erb_user_logic_i.write_word(11'd31, ~d0, 1'b1);
      bwr(REG_CTRL, 32'h20);
      mrd(11'd30, 1'b0, d0);
      erb_user_logic_i.set_ctl(1'b0, 1'b1);
      mrd(11'd31, 1'b0, d0);
      erb_user_logic_i.set_ctl(1'b1, 1'b1);
      mrd(11'd31, 1'b0, ~d0);
      bwr(REG_CTRL, 32'h50);
      erb_user_logic_i.write_word(11'd3, d1, 1'b1);
      mrd(11'd3, 1'b0, d1);
      bwr(REG_CTRL, 32'h0);
      erb_user_logic_i.set_ctl(1'b1, 1'b0);
      erb_user_logic_i.write_word(11'd20, 8'h11, 1'b1);
      mrd(11'd20, 1'b0, 8'h00);
      erb_user_logic_i.set_ctl(1'b1, 1'b1);
      mrd(11'd20, 1'b0, 8'h5a);
      bwr(REG_CTRL, 32'h1);
      erb_user_logic_i.write_word(11'd10, 8'h22, 1'b1);
      mrd(11'd10, 1'b0, 8'h5a);
      bwr(REG_CTRL, 32'h3);
      erb_user_logic_i.write_word(11'd40, d1, 1'b1);
      mrd(11'd40, 1'b1, d1);
      // fifo filled until refused, then drained by one
      bwr(REG_CTRL, 32'h2);
      for (int i = 0; i < 256; i++)
         erb_user_logic_i.write_word(11'h0, 8'(i), 1'b1);
      brd(REG_STATUS, 32'h2100);
      erb_user_logic_i.write_word(11'h0, 8'hee, 1'b1);
      brd(REG_STATUS, 32'h2100);
      mrd(11'h0, 1'b0, 8'h00);
      erb_user_logic_i.pop_word();
      mrd(11'h0, 1'b0, 8'h01);
      brd(REG_STATUS, 32'h00ff);
      repeat (4) @(posedge clock);
      conclude();
   end
endmodule
